/* File: rtl/dma_regs_defines.svh */
// Offsets, field positions and reset values of the DMA register block
`ifndef DMA_REGS_DEFINES_SVH
`define DMA_REGS_DEFINES_SVH

`define OFS_ACTIVE 8'h30
`define OFS_DESC_BASE 8'h34
`define OFS_WB_BASE 8'h38
`define OFS_CHAN_SEL 8'h3f
`define OFS_CTRL_PRI 8'h40
`define OFS_CTRL_SEC 8'h44

`define BIT_CHANNEL_SOFT_RESET 0
`define BIT_EN 1
`define BIT_ACTIVE_BUSY_FLAG 15
`define POS_ID_LO 8
`define POS_ACTIVE_BLOCK_COUNT_LO 16
`define POS_LEVEL_REQUEST_EXECUTING_LO 0

`define POS_CMD_LO 24
`define POS_TRIGGER_ACTION_LO 22
`define POS_TRIGGER_SOURCE_SELECT_LO 8
`define POS_LVL_LO 5
`define BIT_EVENT_OUTPUT_ENABLE 4
`define BIT_EVENT_INPUT_ENABLE 3
`define POS_EVENT_INPUT_ACTION_LO 0

`define RST_VAL32 32'h0000_0000
`define RST_VAL4 4'h0
`define CHANNEL_SOFT_RESET_CYCLES 3'h3
`define NUM_CHANNELS 12

`endif

/* File: rtl/dma_regs_pkg.sv */
// Types shared by the DMA register block and its channel slots
`default_nettype none
package dma_regs_pkg;

typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_SUSPEND = 2'b01,
    CMD_RESUME = 2'b10,
    CMD_RSVD = 2'b11
} sw_cmd_t;

typedef enum logic [1:0] {
    TRIG_BLOCK = 2'b00,
    TRIG_RSVD = 2'b01,
    TRIG_BEAT = 2'b10,
    TRIG_TRANSACTION = 2'b11
} trig_action_t;

typedef struct packed {
    logic enable;
    logic abort_req;
    logic soft_reset;
    logic [2:0] reset_count;
    logic suspend;
    logic resume;
    trig_action_t trig_action;
    logic [5:0] trig_source;
    logic [1:0] level;
    logic event_out_en;
    logic event_in_en;
    logic [2:0] event_action;
} chan_state_t;

typedef struct packed {
    logic [31:0] desc_base;
    logic [31:0] wb_base;
    logic [3:0] chan_sel;
    logic busy;
    logic [4:0] active_index;
    logic [15:0] block_count;
    logic [3:0] level_exec;
    logic [31:0] rd_data;
} regs_state_t;

endpackage
`default_nettype wire

/* File: rtl/dma_channel_slot.sv */
// Control state of one DMA channel: enable, abort, soft reset, control B
`include "dma_regs_defines.svh"
`default_nettype none
module dma_channel_slot (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic sec_wr,
    input wire logic [31:0] sec_wdata,
    input wire logic transfer_active,
    input wire logic abort_done,
    output logic enable,
    output logic abort_req,
    output logic soft_reset,
    output logic suspend_pulse,
    output logic resume_pulse,
    output logic [1:0] trig_action,
    output logic [1:0] level,
    output logic [31:0] sec_rd
);

    dma_regs_pkg::chan_state_t q;
    dma_regs_pkg::chan_state_t d;

    always_comb begin
        d = q;
        d.suspend = 1'b0;
        d.resume = 1'b0;
        if (q.soft_reset) begin
            // Writes are dropped while the reset runs
            if (q.reset_count == `CHANNEL_SOFT_RESET_CYCLES) begin
                d = '0;
            end else begin
                d.reset_count = q.reset_count + 3'h1;
            end
        end else begin
            if (q.abort_req && abort_done) begin
                d.enable = 1'b0;
                d.abort_req = 1'b0;
            end
            if (ctrl_wr) begin
                if (ctrl_wdata[`BIT_CHANNEL_SOFT_RESET]) begin
                    // Whole write dropped while enabled
                    if (!q.enable) begin
                        d = '0;
                        d.soft_reset = 1'b1;
                    end
                end else if (ctrl_wdata[`BIT_EN]) begin
                    d.enable = 1'b1;
                    d.abort_req = 1'b0;
                end else if (d.enable) begin
                    // Stay enabled until the burst drains
                    if (transfer_active) begin
                        d.abort_req = 1'b1;
                    end else begin
                        d.enable = 1'b0;
                    end
                end
            end
            if (sec_wr) begin
                // Command and level are writable while enabled
                case (dma_regs_pkg::sw_cmd_t'(sec_wdata[`POS_CMD_LO +: 2]))
                    dma_regs_pkg::CMD_SUSPEND: begin
                        d.suspend = 1'b1;
                    end
                    dma_regs_pkg::CMD_RESUME: begin
                        d.resume = 1'b1;
                    end
                    default: begin
                    end
                endcase
                d.level = sec_wdata[`POS_LVL_LO +: 2];
                if (!q.enable) begin
                    if (dma_regs_pkg::trig_action_t'(
                        sec_wdata[`POS_TRIGGER_ACTION_LO +: 2]) !=
                        dma_regs_pkg::TRIG_RSVD) begin
                        d.trig_action = dma_regs_pkg::trig_action_t'(
                            sec_wdata[`POS_TRIGGER_ACTION_LO +: 2]);
                    end
                    d.trig_source = sec_wdata[`POS_TRIGGER_SOURCE_SELECT_LO +: 6];
                    d.event_out_en = sec_wdata[`BIT_EVENT_OUTPUT_ENABLE];
                    d.event_in_en = sec_wdata[`BIT_EVENT_INPUT_ENABLE];
                    d.event_action = sec_wdata[`POS_EVENT_INPUT_ACTION_LO +: 3];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign enable = q.enable;
    assign abort_req = q.abort_req;
    assign soft_reset = q.soft_reset;
    assign suspend_pulse = q.suspend;
    assign resume_pulse = q.resume;
    assign trig_action = q.trig_action;
    assign level = q.level;

    // Command field reads zero: it acts as a one-shot strobe
    always_comb begin
        sec_rd = `RST_VAL32;
        sec_rd[`POS_TRIGGER_ACTION_LO +: 2] = q.trig_action;
        sec_rd[`POS_TRIGGER_SOURCE_SELECT_LO +: 6] = q.trig_source;
        sec_rd[`POS_LVL_LO +: 2] = q.level;
        sec_rd[`BIT_EVENT_OUTPUT_ENABLE] = q.event_out_en;
        sec_rd[`BIT_EVENT_INPUT_ENABLE] = q.event_in_en;
        sec_rd[`POS_EVENT_INPUT_ACTION_LO +: 3] = q.event_action;
    end

endmodule
`default_nettype wire

/* File: rtl/dma_channel_config_status_regs.sv */
// Register block of the DMA controller: bases, channel select, status
//
// Decided for this implementation: strobed register access.
`include "dma_regs_defines.svh"
`default_nettype none
// How it works
// - Busy clears when count written back
// - Busy sets when next count fetched
// - Active index latched on each grant
// - Four level executing or pending bits
// - Reserved bits read zero, write zero
// - Channel select steers per-channel access
// - Enable bit starts channel, zero disabled
// - Disable waits for burst and abort
// - Enable bit ignores controller enable
// - Soft reset clears disabled channel registers
// - Soft reset ignored while channel enabled
// - Soft reset reads one until done
// - Active block count in upper half
// - Command: none, suspend, resume, reserved
// - Trigger action: block, beat, transaction
module dma_channel_config_status_regs #(
    parameter int NUM_CH = `NUM_CHANNELS
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [31:0] rd_data,
    input wire logic ctrl_enabled,
    input wire logic grant_valid,
    input wire logic [4:0] grant_channel,
    input wire logic count_fetch_valid,
    input wire logic [15:0] count_fetch_value,
    input wire logic count_writeback_done,
    input wire logic [3:0] level_request,
    input wire logic [NUM_CH-1:0] transfer_active,
    input wire logic [NUM_CH-1:0] abort_done,
    output logic [31:0] desc_base_addr,
    output logic [31:0] wb_base_addr,
    output logic [NUM_CH-1:0] chan_enable,
    output logic [NUM_CH-1:0] chan_abort_req,
    output logic [NUM_CH-1:0] chan_soft_reset,
    output logic [NUM_CH-1:0] chan_suspend,
    output logic [NUM_CH-1:0] chan_resume,
    output logic [2*NUM_CH-1:0] chan_trig_action,
    output logic [2*NUM_CH-1:0] chan_level,
    output logic [3:0] active_channel_sel
);

    dma_regs_pkg::regs_state_t q;
    dma_regs_pkg::regs_state_t d;

    logic sel_ok;
    logic pri_wr;
    logic sec_wr;
    logic [31:0] sec_rd_all [NUM_CH];
    logic [31:0] sec_rd_sel;
    logic [7:0] pri_rd_sel;
    logic [31:0] active_word;

    // Selects above the last channel reach nothing
    assign sel_ok = {1'b0, q.chan_sel} < 5'(NUM_CH);
    assign pri_wr = wr_strobe && (addr == `OFS_CTRL_PRI) && sel_ok;
    assign sec_wr = wr_strobe && (addr == `OFS_CTRL_SEC) && sel_ok;

    // Per-channel access goes to the selected slot
    always_comb begin
        sec_rd_sel = `RST_VAL32;
        pri_rd_sel = 8'h00;
        for (int k = 0; k < NUM_CH; k++) begin
            if (sel_ok && q.chan_sel == 4'(k)) begin
                sec_rd_sel = sec_rd_all[k];
                pri_rd_sel[`BIT_EN] = chan_enable[k];
                pri_rd_sel[`BIT_CHANNEL_SOFT_RESET] = chan_soft_reset[k];
            end
        end
    end

    // Count is shown as held; only meaningful while busy
    always_comb begin
        active_word = `RST_VAL32;
        active_word[`POS_ACTIVE_BLOCK_COUNT_LO +: 16] = q.block_count;
        active_word[`BIT_ACTIVE_BUSY_FLAG] = q.busy;
        active_word[`POS_ID_LO +: 5] = q.active_index;
        active_word[`POS_LEVEL_REQUEST_EXECUTING_LO +: 4] = q.level_exec;
    end

    always_comb begin
        d = q;
        d.level_exec = level_request;
        if (grant_valid) begin
            d.active_index = grant_channel;
        end
        if (count_writeback_done) begin
            d.busy = 1'b0;
        end
        // A fetch in the same cycle as a write-back wins
        if (count_fetch_valid) begin
            d.busy = 1'b1;
            d.block_count = count_fetch_value;
        end
        if (wr_strobe) begin
            case (addr)
                `OFS_DESC_BASE: begin
                    // Alignment is left to software
                    if (!ctrl_enabled) begin
                        d.desc_base = wr_data;
                    end
                end
                `OFS_WB_BASE: begin
                    // Alignment is left to software
                    if (!ctrl_enabled) begin
                        d.wb_base = wr_data;
                    end
                end
                `OFS_CHAN_SEL: begin
                    d.chan_sel = wr_data[3:0];
                end
                default: begin
                end
            endcase
        end
        d.rd_data = `RST_VAL32;
        if (rd_strobe) begin
            case (addr)
                `OFS_ACTIVE: begin
                    d.rd_data = active_word;
                end
                `OFS_DESC_BASE: begin
                    d.rd_data = q.desc_base;
                end
                `OFS_WB_BASE: begin
                    d.rd_data = q.wb_base;
                end
                `OFS_CHAN_SEL: begin
                    d.rd_data = {28'h0000000, q.chan_sel};
                end
                `OFS_CTRL_PRI: begin
                    d.rd_data = {24'h000000, pri_rd_sel};
                end
                `OFS_CTRL_SEC: begin
                    d.rd_data = sec_rd_sel;
                end
                default: begin
                    d.rd_data = `RST_VAL32;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign desc_base_addr = q.desc_base;
    assign wb_base_addr = q.wb_base;
    assign active_channel_sel = q.chan_sel;

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_chan
            // Enable write needs no controller check
            dma_channel_slot u_slot (
                .mclk(mclk),
                .reset(reset),
                .ctrl_wr(pri_wr && q.chan_sel == 4'(i)),
                .ctrl_wdata(wr_data[7:0]),
                .sec_wr(sec_wr && q.chan_sel == 4'(i)),
                .sec_wdata(wr_data),
                .transfer_active(transfer_active[i]),
                .abort_done(abort_done[i]),
                .enable(chan_enable[i]),
                .abort_req(chan_abort_req[i]),
                .soft_reset(chan_soft_reset[i]),
                .suspend_pulse(chan_suspend[i]),
                .resume_pulse(chan_resume[i]),
                .trig_action(chan_trig_action[2*i +: 2]),
                .level(chan_level[2*i +: 2]),
                .sec_rd(sec_rd_all[i])
            );
        end
    endgenerate

endmodule
`default_nettype wire

/* File: test/dma_regs_chk.sv */
// Port assertions for the DMA register block
`default_nettype none
module dma_regs_chk #(
    parameter int NUM_CH = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [31:0] rd_data,
    input wire logic grant_valid,
    input wire logic [4:0] grant_channel,
    input wire logic count_fetch_valid,
    input wire logic count_writeback_done,
    input wire logic [NUM_CH-1:0] abort_done,
    input wire logic [NUM_CH-1:0] chan_enable,
    input wire logic [NUM_CH-1:0] chan_abort_req,
    input wire logic [NUM_CH-1:0] chan_soft_reset,
    input wire logic [3:0] active_channel_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic st_rd, ca_wr, ok_sel;
    logic [3:0] sel_in;
    logic [3:0] sel;
    assign st_rd = rd_strobe && addr == 8'h30;
    assign ca_wr = wr_strobe && addr == 8'h40;
    assign sel = active_channel_sel;
    assign ok_sel = sel < NUM_CH;
    assign sel_in = wr_data[3:0];
    chk_busy_set: assert property (
        count_fetch_valid ##1 !count_writeback_done ##1 st_rd
        |=> rd_data[15]
    ) else $error("busy not set");
    chk_busy_clear: assert property (
        count_writeback_done && !count_fetch_valid ##1 !count_fetch_valid
        ##1 st_rd |=> !rd_data[15]
    ) else $error("busy not cleared");
    chk_index_load: assert property (
        grant_valid ##1 !grant_valid ##1 st_rd
        |=> rd_data[12:8] == $past(grant_channel, 3)
    ) else $error("index not loaded");
    chk_rsvd_zero: assert property (
        st_rd |=> rd_data[14:13] == 2'h0 && rd_data[7:4] == 4'h0
    ) else $error("reserved bits set");
    chk_sel_write: assert property (
        wr_strobe && addr == 8'h3f |=> sel == $past(sel_in)
    ) else $error("select not written");
    chk_enable_set: assert property (
        ca_wr && ok_sel && wr_data[1:0] == 2'h2 && !chan_soft_reset[sel]
        |=> chan_enable[$past(sel)]
    ) else $error("enable not set");
    chk_abort_hold: assert property (
        chan_abort_req[2] && !abort_done[2] |=> chan_enable[2]
    ) else $error("enable dropped early");
    chk_reset_ignored: assert property (
        ca_wr && ok_sel && wr_data[0] && chan_enable[sel]
        |=> !chan_soft_reset[$past(sel)]
    ) else $error("reset while enabled");
    chk_reset_len: assert property (
        $rose(chan_soft_reset[0]) |-> chan_soft_reset[0] [*4] ##1
        !chan_soft_reset[0]
    ) else $error("soft reset length");
    chk_bad_sel: assert property (
        ca_wr && !ok_sel |=> (chan_enable & ~$past(chan_enable)) == '0
    ) else $error("unimplemented channel written");
    cover property (st_rd ##1 rd_data[15]);
    cover property ($rose(chan_soft_reset[0]));
    cover property (chan_abort_req[2] ##1 abort_done[2]);
endmodule
`default_nettype wire

/* File: test/dma_engine_model.sv */
// Behavioural arbiter and transfer engine facing the register block
`default_nettype none
module dma_engine_model (
    input wire logic mclk,
    input wire logic [11:0] abort_req,
    output logic grant_valid,
    output logic [4:0] grant_channel,
    output logic count_fetch_valid,
    output logic [15:0] count_fetch_value,
    output logic count_writeback_done,
    output logic [3:0] level_request,
    output logic [11:0] transfer_active,
    output logic [11:0] abort_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cycles the running burst needs to drain; zero answers at once
    int abort_wait = 4;
    int cnt = 0;
    initial begin
        grant_valid = 1'b0;
        grant_channel = 5'h1f;
        count_fetch_valid = 1'b0;
        count_fetch_value = 16'hffff;
        count_writeback_done = 1'b0;
        level_request = 4'h0;
        transfer_active = 12'h000;
        abort_done = 12'h000;
    end
    always @(posedge mclk) begin
        abort_done <= 12'h000;
        if (abort_req != 12'h000) begin
            cnt <= cnt + 1;
            if (cnt == abort_wait) begin
                abort_done <= abort_req;
            end
        end else begin
            cnt <= 0;
        end
    end
    // Grant and count fetch together; index garbled once invalid
    task automatic grant(input logic [4:0] ch, input logic [15:0] n);
        @(posedge mclk);
        grant_valid <= 1'b1;
        grant_channel <= ch;
        count_fetch_valid <= 1'b1;
        count_fetch_value <= n;
        @(posedge mclk);
        grant_valid <= 1'b0;
        grant_channel <= ~ch;
        count_fetch_valid <= 1'b0;
        count_fetch_value <= ~n;
    endtask
endmodule
`default_nettype wire

/* File: test/dma_channel_config_status_regs_tb_top.sv */
// Self-checking bench for the DMA register block
`default_nettype none
module dma_channel_config_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic ctrl_enabled = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0, rd_data, desc_base_addr, wb_base_addr;
    logic grant_valid, count_fetch_valid, count_writeback_done;
    logic [4:0] grant_channel;
    logic [15:0] count_fetch_value;
    logic [3:0] level_request, active_channel_sel;
    logic [11:0] transfer_active, abort_done, chan_enable, chan_abort_req;
    logic [11:0] chan_soft_reset, chan_suspend, chan_resume;
    logic [23:0] chan_trig_action, chan_level;
    int num_errors = 0;
    int tests_run = 0;
    always #4 mclk = ~mclk;
    dma_channel_config_status_regs dut (.mclk, .reset, .addr, .wr_data,
        .wr_strobe, .rd_strobe, .rd_data, .ctrl_enabled, .grant_valid,
        .grant_channel, .count_fetch_valid, .count_fetch_value,
        .count_writeback_done, .level_request, .transfer_active,
        .abort_done, .desc_base_addr, .wb_base_addr, .chan_enable,
        .chan_abort_req, .chan_soft_reset, .chan_suspend, .chan_resume,
        .chan_trig_action, .chan_level, .active_channel_sel);
    dma_engine_model eng (.mclk, .abort_req(chan_abort_req), .grant_valid,
        .grant_channel, .count_fetch_valid, .count_fetch_value,
        .count_writeback_done, .level_request, .transfer_active,
        .abort_done);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge mclk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge mclk);
        rd_strobe <= 1'b0;
        #1 check(rd_data, exp);
    endtask
    task automatic stop_test;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic t_bases;
        rdc(8'h44, 32'h0);
        rdc(8'h10, 32'h0);
        wr(8'h34, 32'h2000_0010);
        wr(8'h38, 32'h2000_0100);
        ctrl_enabled <= 1'b1;
        wr(8'h34, 32'h0);
        rdc(8'h34, 32'h2000_0010);
        rdc(8'h38, 32'h2000_0100);
        check(desc_base_addr, 32'h2000_0010);
        check(wb_base_addr, 32'h2000_0100);
    endtask
    // Controller stays enabled here: the enable bit must not care
    task automatic t_select;
        wr(8'h3f, 32'h2);
        wr(8'h40, 32'h2);
        rdc(8'h40, 32'h2);
        rdc(8'h3f, 32'h2);
        wr(8'h3f, 32'h5);
        rdc(8'h40, 32'h0);
        wr(8'h3f, 32'hc);
        wr(8'h40, 32'h2);
        rdc(8'h40, 32'h0);
        check({20'h0, chan_enable}, 32'h4);
        ctrl_enabled <= 1'b0;
    endtask
    task automatic t_abort;
        wr(8'h3f, 32'h2);
        eng.transfer_active <= 12'h004;
        wr(8'h40, 32'h0);
        rdc(8'h40, 32'h2);
        check({20'h0, chan_abort_req}, 32'h4);
        repeat (50) if (chan_enable[2]) begin
            @(posedge mclk);
            #1;
        end
        #1 check({20'h0, chan_enable}, 32'h0);
        if (chan_enable[2]) stop_test();
        eng.transfer_active <= 12'h000;
    endtask
    task automatic t_chan_b;
        logic [1:0] act [3] = '{2'h0, 2'h2, 2'h3};
        wr(8'h3f, 32'h0);
        foreach (act[i]) begin
            wr(8'h44, {8'h0, act[i], 22'h40});
            rdc(8'h44, {8'h0, act[i], 22'h40});
        end
        wr(8'h44, 32'h0040_0040);
        rdc(8'h44, 32'h00c0_0040);
        check({30'h0, chan_trig_action[1:0]}, 32'h3);
        check({30'h0, chan_level[1:0]}, 32'h2);
        wr(8'h44, 32'h0100_0040);
        #1 check({20'h0, chan_suspend}, 32'h1);
        wr(8'h44, 32'h0200_0040);
        #1 check({20'h0, chan_resume}, 32'h1);
        wr(8'h44, 32'h0300_0040);
        #1 check({8'h0, chan_suspend, chan_resume}, 32'h0);
        wr(8'h40, 32'h2);
        wr(8'h40, 32'h1);
        rdc(8'h44, 32'h40);
        rdc(8'h40, 32'h2);
        wr(8'h40, 32'h0);
        wr(8'h40, 32'h1);
        rdc(8'h40, 32'h1);
        repeat (4) @(posedge mclk);
        rdc(8'h40, 32'h0);
        rdc(8'h44, 32'h0);
    endtask
    task automatic t_status;
        eng.level_request <= 4'h5;
        eng.grant(5'd7, 16'h1234);
        rdc(8'h30, 32'h1234_8705);
        eng.count_writeback_done <= 1'b1;
        @(posedge mclk);
        eng.count_writeback_done <= 1'b0;
        rdc(8'h30, 32'h1234_0705);
        wr(8'h30, 32'hffff_ffff);
        rdc(8'h30, 32'h1234_0705);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_bases();
        t_select();
        t_abort();
        t_chan_b();
        t_status();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        stop_test();
    end
endmodule
bind dma_channel_config_status_regs dma_regs_chk #(.NUM_CH(NUM_CH)) chk (
    .mclk, .reset, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data,
    .grant_valid, .grant_channel, .count_fetch_valid, .count_writeback_done,
    .abort_done, .chan_enable, .chan_abort_req, .chan_soft_reset,
    .active_channel_sel);
`default_nettype wire
